// ---- hall_sensor_cycle_readout.sv ----
// measurement-cycle sequencer with done pulse and result read windows
//
// Behaviour
// - enabled done line pulses low per cycle
// - fast mode restarts cycle at once
// - other modes start only on a trigger
// - four channels end after temperature
// - three channels skip temperature, end after z
// - planar config converts x,y only, ends after y
// - master mode converts only on bus trigger
`timescale 1ns/1ps
module hall_sensor_cycle_readout
   import hall_readout_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic          clk_sys,       // system clock, 50 MHz
   input  wire logic          rstn,          // async reset, low
   input  wire op_mode_type   op_mode,       // operating mode
   input  wire chan_cfg_type  chan_cfg,      // channel set
   input  wire logic          short_range,   // short range windows
   input  wire logic          int_enable,    // done pulse enabled
   input  wire logic          trig_internal, // rate timer trigger
   input  wire logic          trig_bus,      // trigger from the bus
   output logic               adc_start,     // start conversion
   output chan_type           adc_chan,      // channel to convert
   input  wire logic          adc_done,      // conversion finished
   input  wire logic [FIELD_W-1:0] adc_data, // conversion result
   output result_set_type     results,       // latest results
   output logic               cycle_busy,    // cycle in progress
   output logic               int_n,         // done line, low
   output logic               rd_valid,      // result word ready
   input  wire logic          rd_ready,      // bus takes a word
   output result_word_type    rd_data,       // oldest result word
   output logic               first_read_window, // first read ok
   output logic               next_read_window   // next read ok
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_WAIT
   } seq_state_type;

   seq_state_type   state_ff;               // sequencer state
   chan_type        chan_ff;                // channel in work
   chan_cfg_type    cfg_ff;                 // config of this cycle
   result_set_type  results_ff;             // stored results
   chan_type        last_chan;              // final channel of cycle
   logic            start_req;              // new cycle wanted
   logic            cycle_end;              // last conversion done
   logic            fifo_in_ready;          // room for a result
   result_word_type push_word;              // word into the fifo
   logic            int_active;             // pulse in progress
   logic            int_active_d_ff;        // previous pulse level
   logic            int_rise;               // end of the pulse
   logic            rd_pop;                 // word handed out
   logic [WIN_W-1:0] win_cnt_ff;            // cycles since anchor
   logic            win_first_ff;           // anchor was the pulse
   logic            win_run_ff;             // window timing live
   logic [WIN_W-1:0] win_min;               // opening count
   logic [WIN_W-1:0] win_max;               // closing count
   logic            win_open;               // inside the window

   // ---------------------------------------------------------------
   // trigger decode
   // ---------------------------------------------------------------
   // fast mode needs no trigger, master mode listens only to the bus
   always_comb begin
      case (op_mode)
         MODE_FAST:      start_req = 1'b1;
         MODE_LOW_POWER: start_req = trig_internal;
         MODE_MASTER:    start_req = trig_bus;
         default:        start_req = 1'b0;          // power down
      endcase
   end

   // final channel per configuration
   always_comb begin
      case (cfg_ff)
         CFG_XYZT: last_chan = CH_T;
         CFG_XYZ:  last_chan = CH_Z;
         CFG_XY:   last_chan = CH_Y;
         default:  last_chan = CH_T;
      endcase
   end

   assign cycle_end  = (state_ff == ST_WAIT) && adc_done
                       && (chan_ff == last_chan);
   // a conversion starts only with fifo room, so the push never drops
   assign adc_start  = (state_ff == ST_START) && fifo_in_ready;
   assign adc_chan   = chan_ff;
   assign cycle_busy = state_ff != ST_IDLE;
   assign results    = results_ff;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // triggers that arrive during a cycle are ignored, not queued
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start_req) begin
                  state_ff <= ST_START;
               end
            end
            ST_START: begin
               if (fifo_in_ready) begin
                  state_ff <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (cycle_end) begin
                  // back to back cycles in fast mode
                  state_ff <= (op_mode == MODE_FAST) ? ST_START
                                                     : ST_IDLE;
               end else if (adc_done) begin
                  state_ff <= ST_START;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // channel walk: x, y, z, then temperature
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         chan_ff <= CH_X;
      end else if (cycle_end) begin
         chan_ff <= CH_X;
      end else if ((state_ff == ST_WAIT) && adc_done) begin
         chan_ff <= chan_type'(chan_ff + 2'h1);
      end
   end

   // config is frozen per cycle so a change never cuts one short
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cfg_ff <= CFG_XYZT;
      end else if ((state_ff == ST_IDLE) || cycle_end) begin
         cfg_ff <= chan_cfg;
      end
   end

   // ---------------------------------------------------------------
   // result store, unconverted channels keep old values
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         results_ff <= '0;
      end else if ((state_ff == ST_WAIT) && adc_done) begin
         case (chan_ff)
            CH_X:    results_ff.x <= adc_data;
            CH_Y:    results_ff.y <= adc_data;
            CH_Z:    results_ff.z <= adc_data;
            CH_T:    results_ff.t <= adc_data[TEMP_W-1:0];
            default: results_ff.x <= results_ff.x;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // result fifo toward the bus
   // ---------------------------------------------------------------
   // one driver for the whole word, channel tag beside the data
   assign push_word = '{chan: chan_ff, data: adc_data};
   assign rd_pop         = rd_valid && rd_ready;

   result_fifo #(
      .WIDTH ($bits(result_word_type)),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_valid  ((state_ff == ST_WAIT) && adc_done),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word),
      .out_valid (rd_valid),
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

   // ---------------------------------------------------------------
   // end of conversion pulse
   // ---------------------------------------------------------------
   pulse_timer #(
      .W   (INT_W),
      .LEN (INT_CYC)
   ) u_int_pulse (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .load    (cycle_end && int_enable),
      .active  (int_active)
   );

   // line idles high, low only while the pulse runs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         int_n <= 1'b1;
      end else begin
         int_n <= !int_active;
      end
   end

   // delayed level marks the rising edge of the line
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         int_active_d_ff <= 1'b0;
      end else begin
         int_active_d_ff <= int_active;
      end
   end

   assign int_rise = int_active_d_ff && !int_active;

   // ---------------------------------------------------------------
   // read windows
   // ---------------------------------------------------------------
   // limits from min/max figures; the master should aim at the low end
   always_comb begin
      case ({win_first_ff, short_range})
         2'h3:    begin win_min = WIN_W'(RD1SR_MIN_CYC);
                        win_max = WIN_W'(RD1SR_MAX_CYC); end
         2'h2:    begin win_min = WIN_W'(RD1_MIN_CYC);
                        win_max = WIN_W'(RD1_MAX_CYC); end
         2'h1:    begin win_min = WIN_W'(RDNSR_MIN_CYC);
                        win_max = WIN_W'(RDNSR_MAX_CYC); end
         default: begin win_min = WIN_W'(RDN_MIN_CYC);
                        win_max = WIN_W'(RDN_MAX_CYC); end
      endcase
   end

   // anchored at pulse end, re-anchored by each word taken while window timing is live
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         win_cnt_ff   <= '0;
         win_first_ff <= 1'b1;
         win_run_ff   <= 1'b0;
      end else if (int_rise) begin
         win_cnt_ff   <= '0;
         win_first_ff <= 1'b1;
         win_run_ff   <= 1'b1;
      end else if (rd_pop && win_run_ff) begin
         win_cnt_ff   <= '0;
         win_first_ff <= 1'b0;
      end else if (win_run_ff) begin
         if (win_cnt_ff >= win_max) begin
            win_run_ff <= 1'b0;                     // window missed
         end else begin
            win_cnt_ff <= win_cnt_ff + 1'b1;
         end
      end
   end

   assign win_open = win_run_ff && (win_cnt_ff >= win_min)
                     && (win_cnt_ff <= win_max);
   assign first_read_window = win_open && win_first_ff;
   assign next_read_window  = win_open && !win_first_ff;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   logic [INT_W-1:0] low_cnt_ff;            // helper: low length

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         low_cnt_ff <= '0;
      end else if (!int_n) begin
         low_cnt_ff <= low_cnt_ff + 1'b1;
      end else begin
         low_cnt_ff <= '0;
      end
   end

   int_width_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(int_n) |-> low_cnt_ff == INT_W'(INT_CYC))
      else $error("done pulse width wrong");

   int_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      cycle_end && int_enable |-> ##2 !int_n)
      else $error("done pulse missing after cycle");

   int_cause_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      $fell(int_n) |-> $past(cycle_end && int_enable, 2))
      else $error("done pulse without enabled cycle end");

   fast_again_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      cycle_end && op_mode == MODE_FAST |=> state_ff == ST_START)
      else $error("fast mode did not restart");

   need_trig_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_ff == ST_IDLE && op_mode != MODE_FAST && !trig_internal
      && !trig_bus |=> state_ff == ST_IDLE)
      else $error("cycle started without trigger");

   bus_only_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_ff == ST_IDLE && op_mode == MODE_MASTER && !trig_bus
      |=> state_ff == ST_IDLE)
      else $error("master mode started without bus trigger");

   temp_last_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_ff == ST_WAIT && adc_done && chan_ff != CH_T
      && cfg_ff == CFG_XYZT |=> chan_ff != CH_X)
      else $error("four channel cycle ended early");

   keep_temp_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      state_ff == ST_WAIT && cfg_ff == CFG_XYZ |->
      chan_ff != CH_T ##1 results_ff.t == $past(results_ff.t))
      else $error("three channel cycle touched temperature");

   planar_only_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      adc_start && cfg_ff == CFG_XY |-> adc_chan inside {CH_X, CH_Y})
      else $error("planar cycle converted z or temperature");

   fast_end_c: cover property (@(posedge clk_sys) disable iff (!rstn)
      cycle_end && op_mode == MODE_FAST ##1 state_ff == ST_START);
   xyz_end_c: cover property (@(posedge clk_sys) disable iff (!rstn)
      cycle_end && cfg_ff == CFG_XYZ);
   first_win_c: cover property (@(posedge clk_sys) disable iff (!rstn)
      first_read_window && rd_pop);
endmodule

// ---- hall_readout_pkg.sv ----
// shared constants and types for the measurement-cycle readout block
package hall_readout_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ       = 50;      // system clock rate
   localparam int INT_PULSE_NS  = 2500;    // done pulse, typical width
   localparam int RD1_MIN_NS    = 30000;   // first read, full range
   localparam int RD1_MAX_NS    = 50000;
   localparam int RD1SR_MIN_NS  = 42000;   // first read, short range
   localparam int RD1SR_MAX_NS  = 70000;
   localparam int RDN_MIN_NS    = 32000;   // next read, full range
   localparam int RDN_MAX_NS    = 54000;
   localparam int RDNSR_MIN_NS  = 44000;   // next read, short range
   localparam int RDNSR_MAX_NS  = 74000;

   // typical width sits inside the 1.8 to 3.2 us band
   localparam int INT_CYC       = INT_PULSE_NS * CLK_MHZ / 1000;
   // least times round up, longest times round down
   localparam int RD1_MIN_CYC   = (RD1_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RD1_MAX_CYC   = RD1_MAX_NS * CLK_MHZ / 1000;
   localparam int RD1SR_MIN_CYC = (RD1SR_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RD1SR_MAX_CYC = RD1SR_MAX_NS * CLK_MHZ / 1000;
   localparam int RDN_MIN_CYC   = (RDN_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RDN_MAX_CYC   = RDN_MAX_NS * CLK_MHZ / 1000;
   localparam int RDNSR_MIN_CYC = (RDNSR_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RDNSR_MAX_CYC = RDNSR_MAX_NS * CLK_MHZ / 1000;

   localparam int WIN_W         = 12;      // holds 3700 cycles
   localparam int INT_W         = 8;       // holds the pulse count

   // ---------------------------------------------------------------
   // data widths and buffering
   // ---------------------------------------------------------------
   localparam int FIELD_W       = 12;      // field channel result
   localparam int TEMP_W        = 10;      // temperature result
   localparam int FIFO_DEPTH    = 16;      // result words buffered

   // ---------------------------------------------------------------
   // modes, configurations, channels
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_POWER_DOWN,
      MODE_LOW_POWER,
      MODE_FAST,
      MODE_MASTER
   } op_mode_type;

   typedef enum logic [1:0] {
      CFG_XYZT,
      CFG_XYZ,
      CFG_XY
   } chan_cfg_type;

   typedef enum logic [1:0] {
      CH_X,
      CH_Y,
      CH_Z,
      CH_T
   } chan_type;

   typedef struct packed {
      chan_type           chan;            // which channel
      logic [FIELD_W-1:0] data;            // converted value
   } result_word_type;

   typedef struct packed {
      logic [FIELD_W-1:0] x;               // field_x_result
      logic [FIELD_W-1:0] y;               // field_y_result
      logic [FIELD_W-1:0] z;               // field_z_result
      logic [TEMP_W-1:0]  t;               // temperature result
   } result_set_type;

endpackage

// ---- result_fifo.sv ----
// synchronous result fifo with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,   // system clock
   input  wire logic             rstn,      // async reset, low
   input  wire logic             in_valid,  // write request
   output logic                  in_ready,  // room for a word
   input  wire logic [WIDTH-1:0] in_data,   // word written
   output logic                  out_valid, // word available
   input  wire logic             out_ready, // reader takes word
   output logic [WIDTH-1:0]      out_data   // oldest word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];          // storage array
   logic [AW:0]      wr_ptr_ff;            // extra bit tells full
   logic [AW:0]      rd_ptr_ff;
   logic             push;
   logic             pop;

   assign in_ready  = (wr_ptr_ff ^ rd_ptr_ff) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr_ff != rd_ptr_ff;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr_ff[AW-1:0]];

   // ---------------------------------------------------------------
   // storage, no reset needed on data
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_ff[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
      end
   end
endmodule

// ---- pulse_timer.sv ----
// one-shot timer: holds active for a fixed number of cycles
`timescale 1ns/1ps
module pulse_timer #(
   parameter int W   = 8,
   parameter int LEN = 125
) (
   input  wire logic clk_sys,               // system clock
   input  wire logic rstn,                  // async reset, low
   input  wire logic load,                  // start the pulse
   output logic      active                 // high for LEN cycles
);
   logic [W-1:0] cnt_ff;                    // cycles left

   assign active = cnt_ff != '0;

   // reload wins, so a late load never shortens the pulse
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= W'(LEN);
      end else if (active) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule

// ---- sensor_partner.sv ----
// far-side model: converter answering starts, reader taking words
`timescale 1ns/1ps
module sensor_partner
   import hall_readout_pkg::*;
(
   input  wire logic               clk_sys,   // system clock
   input  wire logic               rstn,      // async reset, low
   input  wire logic               adc_start, // conversion request
   input  wire chan_type           adc_chan,  // channel asked for
   output logic                    adc_done,  // one-cycle done
   output logic [FIELD_W-1:0]      adc_data,  // result word
   input  wire logic [9:0]         pat,       // value pattern
   input  wire logic [7:0]         lat,       // conversion latency
   input  wire logic               take_en,   // reader willing
   output logic                    rd_ready   // reader takes word
);
   int cnt; // cycles left in conversion, 0 when idle

   // reader paced by the bench, which does not keep to the read windows
   assign rd_ready = take_en;

   // converter: data toggles while not valid so stale values never match
   always @(negedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         adc_done <= 1'b0;
         adc_data <= 12'hFFF;
      end else if (adc_start) begin
         cnt <= lat;
         adc_done <= 1'b0;
         adc_data <= ~adc_data;
      end else if (cnt == 1) begin
         cnt <= 0;
         adc_done <= 1'b1;
         adc_data <= {adc_chan, pat};
      end else begin
         if (cnt > 0)
            cnt <= cnt - 1;
         adc_done <= 1'b0;
         adc_data <= ~adc_data;
      end
   end
endmodule

// ---- tb.sv ----
// self-checking bench for the measurement-cycle readout block
`timescale 1ns/1ps
module tb;
   import hall_readout_pkg::*;
   // ---------------------------------------------------------------
   // stimulus, observed signals, monitors
   // ---------------------------------------------------------------
   logic clk_sys = 0, rstn = 0, short_range = 0, int_enable = 1;
   logic trig_internal = 0, trig_bus = 0, take_en = 1;
   op_mode_type op_mode = MODE_MASTER;
   chan_cfg_type chan_cfg = CFG_XYZT;
   logic [9:0] pat = 10'h000;
   logic [7:0] lat = 8'h04;
   logic adc_start, adc_done, cycle_busy, int_n, rd_valid, rd_ready;
   logic first_read_window, next_read_window;
   chan_type adc_chan;
   logic [FIELD_W-1:0] adc_data;
   result_set_type results;
   result_word_type rd_data;
   result_word_type q[$]; // words taken by the reader
   int fail_count = 0, cmp_count = 0, starts = 0, pulses = 0;
   int low_len = 0, last_len = 0, cycles = 0, rise_at = 0;

   always #10 clk_sys = ~clk_sys;

   hall_sensor_cycle_readout u_dut (.clk_sys, .rstn, .op_mode, .chan_cfg,
      .short_range, .int_enable, .trig_internal, .trig_bus, .adc_start,
      .adc_chan, .adc_done, .adc_data, .results, .cycle_busy, .int_n,
      .rd_valid, .rd_ready, .rd_data, .first_read_window,
      .next_read_window);
   sensor_partner u_partner (.clk_sys, .rstn, .adc_start, .adc_chan,
      .adc_done, .adc_data, .pat, .lat, .take_en, .rd_ready);

   // counts starts, taken words, done pulses and their width; timeout
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (adc_start === 1'b1)
         starts <= starts + 1;
      if (rd_valid === 1'b1 && rd_ready)
         q.push_back(rd_data);
      if (int_n === 1'b0)
         low_len <= low_len + 1;
      else if (low_len > 0) begin
         last_len <= low_len;
         pulses <= pulses + 1;
         low_len <= 0;
         rise_at <= cycles;
      end
      if (cycles == 40000) begin
         fail_count++;
         conclude();
      end
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one bus-triggered cycle, then room for the done pulse to end
   task automatic run_cycle(chan_cfg_type cfg, logic [9:0] p);
      int n = 0;
      @(negedge clk_sys);
      chan_cfg = cfg;
      pat = p;
      trig_bus = 1;
      q.delete();
      @(negedge clk_sys);
      trig_bus = 0;
      while (cycle_busy !== 1'b0 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      repeat (140) @(negedge clk_sys);
   endtask
   task automatic check_words(int n, logic [9:0] p);
      check("word count", q.size(), n);
      foreach (q[i]) check("word", q[i], {2'(i), 2'(i), p});
   endtask
   task automatic wait_to(int t);
      while (cycles < t) @(negedge clk_sys);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      check("reset results", results, 0);
      check("reset done line", int_n, 1);
      check("reset busy", cycle_busy, 0);
      check("reset valid", {rd_valid, first_read_window}, 0);
   endtask
   task automatic t_four();
      int p0 = pulses;
      run_cycle(CFG_XYZT, 10'h0A1);
      check_words(4, 10'h0A1);
      check("results", results,
         {2'h0, 10'h0A1, 2'h1, 10'h0A1, 2'h2, 10'h0A1, 10'h0A1});
      check("pulse count", pulses - p0, 1);
      check("pulse width", last_len, INT_CYC);
   endtask
   task automatic t_three();
      run_cycle(CFG_XYZ, 10'h0B2);
      check_words(3, 10'h0B2);
      check("results", results,
         {2'h0, 10'h0B2, 2'h1, 10'h0B2, 2'h2, 10'h0B2, 10'h0A1});
   endtask
   task automatic t_planar();
      run_cycle(CFG_XY, 10'h0C3);
      check_words(2, 10'h0C3);
      check("results", results,
         {2'h0, 10'h0C3, 2'h1, 10'h0C3, 2'h2, 10'h0B2, 10'h0A1});
   endtask
   task automatic t_no_int();
      int p0 = pulses;
      int_enable = 0;
      run_cycle(CFG_XYZT, 10'h0D4);
      check("masked pulses", pulses - p0, 0);
      int_enable = 1;
   endtask
   // wrong trigger sources and modes must not start a cycle
   task automatic t_trig();
      int s0 = starts;
      op_mode = MODE_POWER_DOWN;
      trig_bus = 1;
      trig_internal = 1;
      repeat (50) @(negedge clk_sys);
      check("power down starts", starts - s0, 0);
      op_mode = MODE_MASTER;
      trig_bus = 0;
      repeat (50) @(negedge clk_sys);
      check("master internal", starts - s0, 0);
      op_mode = MODE_LOW_POWER;
      trig_bus = 1;
      trig_internal = 0;
      repeat (50) @(negedge clk_sys);
      check("low power bus", starts - s0, 0);
      trig_bus = 0;
      trig_internal = 1;
      @(negedge clk_sys);
      trig_internal = 0;
      repeat (200) @(negedge clk_sys);
      check("low power cycle", starts - s0, 4);
      op_mode = MODE_MASTER;
   endtask
   // first read window timed from the end of the done pulse
   task automatic t_window();
      int lo, hi, t0;
      for (int sr = 0; sr < 2; sr++) begin
         lo = sr ? RD1SR_MIN_CYC : RD1_MIN_CYC;
         hi = sr ? RD1SR_MAX_CYC : RD1_MAX_CYC;
         short_range = sr[0];
         take_en = 0;
         run_cycle(CFG_XYZT, 10'h155);
         wait_to(rise_at + lo - 50);
         check("window early", first_read_window, 0);
         wait_to(rise_at + (lo + hi) / 2);
         check("window open", first_read_window, 1);
         wait_to(rise_at + hi + 50);
         check("window late", first_read_window, 0);
         take_en = 1;
         repeat (10) @(negedge clk_sys);
         // next window: one word taken at the first window's opening
         take_en = 0;
         run_cycle(CFG_XYZT, 10'h0E5);
         wait_to(rise_at + lo);
         take_en = 1;
         @(negedge clk_sys);
         take_en = 0;
         t0 = cycles;
         lo = sr ? RDNSR_MIN_CYC : RDN_MIN_CYC;
         hi = sr ? RDNSR_MAX_CYC : RDN_MAX_CYC;
         wait_to(t0 + lo - 50);
         check("next early", next_read_window, 0);
         wait_to(t0 + (lo + hi) / 2);
         check("next open", {first_read_window, next_read_window}, 1);
         wait_to(t0 + hi + 50);
         check("next late", next_read_window, 0);
         take_en = 1;
         repeat (10) @(negedge clk_sys);
      end
      short_range = 0;
   endtask
   // free running cycles with the reader stalled until the fifo refuses
   task automatic t_fast();
      int s0 = starts;
      int p0 = pulses;
      take_en = 0;
      lat = 8'h50;
      chan_cfg = CFG_XY;
      q.delete();
      op_mode = MODE_FAST;
      repeat (2500) @(negedge clk_sys);
      check("starts until full", starts - s0, FIFO_DEPTH);
      check("full valid", rd_valid, 1);
      op_mode = MODE_MASTER;
      take_en = 1;
      repeat (600) @(negedge clk_sys);
      check("drained words", q.size(), FIFO_DEPTH + 2);
      check("drained empty", rd_valid, 0);
      check("fast pulses", pulses - p0, 9);
   endtask

   initial begin
      repeat (20) @(negedge clk_sys);
      t_reset();
      rstn = 1;
      t_four();
      t_three();
      t_planar();
      t_no_int();
      t_trig();
      t_window();
      t_fast();
      conclude();
   end
endmodule
